// file: logic/sys_timers.sv
// System timers: two 16-bit timers on pclk and one 24-bit timer, APB register access
// Function
// - Third and fourth timers are 16-bit, reload or free-run, clocked by pclk
// - Fourth overflow flag, bit 7, set on overflow, held until software clears
// - Bit 6 selects auto-reload for fourth timer when 1, free-run when 0
// - Bit 5 makes fourth timer count when set, halts when clear
// - Bit 4 passes fourth timer overflow interrupt when 1
// - Third overflow flag, bit 3, set on overflow, cleared only by software write
// - Bit 2 selects auto-reload for third timer when 1, free-run when 0
// - Bit 1 makes third timer count when set, stops when clear
// - Bit 0 passes third timer overflow interrupt when 1
// - 16-bit count write loads reload value in reload mode, live count otherwise
// - Count byte reads return the live count, no snapshot
// - Fifth timer is 24-bit, free-run or auto-reload
// - Fifth timer counts on its selected clock tick, even in stop or sleep
// - Clock select bits 6:5: 00/01 fast oscillator, 10/11 slow 32k oscillator
// - Fifth overflow flag, bit 7, set on 24-bit overflow, cleared by software
// - Bit 4 selects auto-reload for fifth timer when 1, free-run when 0
// - Bit 3 runs fifth timer; bits 2 and 1 unused
// - Bit 0 passes fifth timer overflow interrupt when 1
// - 24-bit count write loads reload value in reload mode, live count otherwise
module sys_timers (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Fifth timer clock source ticks, one pclk cycle each
    input wire logic fast_internal_oscillator,
    input wire logic slow_oscillator_32k,
    // Overflow interrupt requests
    output logic third_irq,
    output logic fourth_irq,
    output logic fifth_irq
);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0] ctl34_q;
    logic [7:0] ctl5_q;
    logic [15:0] cnt3_q;
    logic [15:0] cnt4_q;
    logic [23:0] cnt5_q;
    logic [15:0] rld3_q;
    logic [15:0] rld4_q;
    logic [23:0] rld5_q;
    logic [31:0] prdata_q;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    logic acc;
    logic wr;
    logic [15:0] idx;
    logic hit;
    logic [7:0] wb;
    logic [7:0] rd_d;
    logic bad;

    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign idx = paddr[17:2];
    assign wb = pwdata[7:0];
    // Zero-wait slave; pready is held high so every access completes in two cycles
    assign pready = 1'b1;
    assign prdata = prdata_q;

    always_comb begin
        hit = 1'b1;
        rd_d = 8'h00;
        unique case (idx)
            sys_timers_pkg::timer_four_count_low_idx: rd_d = cnt4_q[7:0];
            sys_timers_pkg::timer_four_count_high_idx: rd_d = cnt4_q[15:8];
            sys_timers_pkg::timer_three_count_low_idx: rd_d = cnt3_q[7:0];
            sys_timers_pkg::timer_three_count_high_idx: rd_d = cnt3_q[15:8];
            sys_timers_pkg::timers_three_four_control_idx: rd_d = ctl34_q;
            sys_timers_pkg::timer_five_control_idx: rd_d = ctl5_q;
            sys_timers_pkg::timer_five_count_low_idx: rd_d = cnt5_q[7:0];
            sys_timers_pkg::timer_five_count_mid_idx: rd_d = cnt5_q[15:8];
            sys_timers_pkg::timer_five_count_top_idx: rd_d = cnt5_q[23:16];
            default: hit = 1'b0;
        endcase
    end

    // Unmapped or misaligned words answer with an error and read zero
    assign bad = paddr[1:0] != 2'b00 || paddr[31:18] != 14'h0000;
    assign pslverr = acc && (!hit || bad);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            // Masked so a misaligned read cannot alias a live register
            prdata_q <= {24'h000000, bad ? 8'h00 : rd_d};
        end
    end

    logic wok;
    assign wok = wr && !pslverr;

    // ----------------------------------------------------------------
    // Per-byte write strobes
    // ----------------------------------------------------------------
    logic w_c34;
    logic w_c5;
    logic [1:0] w3;
    logic [1:0] w4;
    logic [2:0] w5;

    assign w_c34 = wok && idx == sys_timers_pkg::timers_three_four_control_idx;
    assign w_c5 = wok && idx == sys_timers_pkg::timer_five_control_idx;
    assign w3 = {wok && idx == sys_timers_pkg::timer_three_count_high_idx,
                 wok && idx == sys_timers_pkg::timer_three_count_low_idx};
    assign w4 = {wok && idx == sys_timers_pkg::timer_four_count_high_idx,
                 wok && idx == sys_timers_pkg::timer_four_count_low_idx};
    assign w5 = {wok && idx == sys_timers_pkg::timer_five_count_top_idx,
                 wok && idx == sys_timers_pkg::timer_five_count_mid_idx,
                 wok && idx == sys_timers_pkg::timer_five_count_low_idx};

    // ----------------------------------------------------------------
    // Control fields
    // ----------------------------------------------------------------
    logic run3;
    logic run4;
    logic run5;
    logic rl3;
    logic rl4;
    logic rl5;
    logic tick5;

    assign run3 = ctl34_q[sys_timers_pkg::third_run_bit];
    assign run4 = ctl34_q[sys_timers_pkg::fourth_run_bit];
    assign run5 = ctl5_q[sys_timers_pkg::fifth_run_bit];
    assign rl3 = ctl34_q[sys_timers_pkg::third_reload_select_bit];
    assign rl4 = ctl34_q[sys_timers_pkg::fourth_reload_select_bit];
    assign rl5 = ctl5_q[sys_timers_pkg::fifth_reload_select_bit];
    // The high select bit alone decides, so codes 00/01 and 10/11 are alike
    assign tick5 = ctl5_q[sys_timers_pkg::fifth_clock_select_hi_bit] ?
                   slow_oscillator_32k : fast_internal_oscillator;

    // Overflow: counter at all ones while a count step is taken
    logic ovf3;
    logic ovf4;
    logic ovf5;
    assign ovf3 = run3 && cnt3_q == 16'hffff;
    assign ovf4 = run4 && cnt4_q == 16'hffff;
    assign ovf5 = run5 && tick5 && cnt5_q == 24'hffffff;

    // ----------------------------------------------------------------
    // Shared control register; hardware set wins over software clear
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl34_q <= sys_timers_pkg::control_reset;
        end else begin
            if (w_c34) begin
                ctl34_q <= wb;
            end
            if (ovf4) begin
                ctl34_q[sys_timers_pkg::fourth_overflow_flag_bit] <= 1'b1;
            end
            if (ovf3) begin
                ctl34_q[sys_timers_pkg::third_overflow_flag_bit] <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl5_q <= sys_timers_pkg::control_reset;
        end else begin
            if (w_c5) begin
                ctl5_q <= wb & sys_timers_pkg::fifth_control_write_mask;
            end
            if (ovf5) begin
                ctl5_q[sys_timers_pkg::fifth_overflow_flag_bit] <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Third timer
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt3_q <= sys_timers_pkg::count16_reset;
            rld3_q <= sys_timers_pkg::count16_reset;
        end else begin
            if (ovf3) begin
                cnt3_q <= rl3 ? rld3_q : 16'h0000;
            end else if (run3) begin
                cnt3_q <= cnt3_q + 16'h0001;
            end
            // A software write lands last and overrides the count step
            if (w3[0]) begin
                if (rl3) rld3_q[7:0] <= wb;
                else cnt3_q[7:0] <= wb;
            end
            if (w3[1]) begin
                if (rl3) rld3_q[15:8] <= wb;
                else cnt3_q[15:8] <= wb;
            end
        end
    end

    // ----------------------------------------------------------------
    // Fourth timer
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt4_q <= sys_timers_pkg::count16_reset;
            rld4_q <= sys_timers_pkg::count16_reset;
        end else begin
            if (ovf4) begin
                cnt4_q <= rl4 ? rld4_q : 16'h0000;
            end else if (run4) begin
                cnt4_q <= cnt4_q + 16'h0001;
            end
            if (w4[0]) begin
                if (rl4) rld4_q[7:0] <= wb;
                else cnt4_q[7:0] <= wb;
            end
            if (w4[1]) begin
                if (rl4) rld4_q[15:8] <= wb;
                else cnt4_q[15:8] <= wb;
            end
        end
    end

    // ----------------------------------------------------------------
    // Fifth timer; steps only on ticks of the selected source
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt5_q <= sys_timers_pkg::count24_reset;
            rld5_q <= sys_timers_pkg::count24_reset;
        end else begin
            if (ovf5) begin
                cnt5_q <= rl5 ? rld5_q : 24'h000000;
            end else if (run5 && tick5) begin
                cnt5_q <= cnt5_q + 24'h000001;
            end
            for (int b = 0; b < 3; b++) begin
                if (w5[b]) begin
                    if (rl5) rld5_q[b*8 +: 8] <= wb;
                    else cnt5_q[b*8 +: 8] <= wb;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupt requests
    // ----------------------------------------------------------------
    assign third_irq = ctl34_q[sys_timers_pkg::third_overflow_flag_bit] &&
                       ctl34_q[sys_timers_pkg::third_irq_enable_bit];
    assign fourth_irq = ctl34_q[sys_timers_pkg::fourth_overflow_flag_bit] &&
                        ctl34_q[sys_timers_pkg::fourth_irq_enable_bit];
    assign fifth_irq = ctl5_q[sys_timers_pkg::fifth_overflow_flag_bit] &&
                       ctl5_q[sys_timers_pkg::fifth_irq_enable_bit];

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // An overflow sets its flag; it stays set until a control register write
    third_flag_set_a: assert property (ovf3 |=> ctl34_q[3])
        else $error("third overflow did not set flag");

    fourth_flag_set_a: assert property (ovf4 |=> ctl34_q[7])
        else $error("fourth overflow did not set flag");

    fifth_flag_set_a: assert property (ovf5 |=> ctl5_q[7])
        else $error("fifth overflow did not set flag");

    fourth_flag_hold_a: assert property (ctl34_q[7] && !w_c34 |=> ctl34_q[7])
        else $error("fourth flag dropped without write");

    third_flag_hold_a: assert property (ctl34_q[3] && !w_c34 |=> ctl34_q[3])
        else $error("third flag dropped without write");

    fifth_flag_hold_a: assert property (ctl5_q[7] && !w_c5 |=> ctl5_q[7])
        else $error("fifth flag dropped without write");

    third_stop_a: assert property (!run3 && w3 == 2'b00 |=> $stable(cnt3_q))
        else $error("third timer moved while stopped");

    fourth_stop_a: assert property (!run4 && w4 == 2'b00 |=> $stable(cnt4_q))
        else $error("fourth timer moved while stopped");

    fifth_stop_a: assert property (!run5 && w5 == 3'b000 |=> $stable(cnt5_q))
        else $error("fifth timer moved while stopped");

    fourth_count_a: assert property (run4 && !ovf4 && w4 == 2'b00
        |=> cnt4_q == $past(cnt4_q) + 16'h0001)
        else $error("fourth timer did not step");

    third_count_a: assert property (run3 && !ovf3 && w3 == 2'b00
        |=> cnt3_q == $past(cnt3_q) + 16'h0001)
        else $error("third timer did not step");

    fifth_count_a: assert property (run5 && tick5 && !ovf5 && w5 == 3'b000
        |=> cnt5_q == $past(cnt5_q) + 24'h000001)
        else $error("fifth timer did not step");

    third_reload_a: assert property (ovf3 && rl3 && w3 == 2'b00
        |=> cnt3_q == $past(rld3_q))
        else $error("third timer did not reload");

    fourth_reload_a: assert property (ovf4 && rl4 && w4 == 2'b00
        |=> cnt4_q == $past(rld4_q))
        else $error("fourth timer did not reload");

    fifth_reload_a: assert property (ovf5 && rl5 && w5 == 3'b000
        |=> cnt5_q == $past(rld5_q))
        else $error("fifth timer did not reload");

    fourth_wrap_a: assert property (ovf4 && !rl4 && w4 == 2'b00
        |=> cnt4_q == 16'h0000)
        else $error("fourth timer did not wrap");

    third_wrap_a: assert property (ovf3 && !rl3 && w3 == 2'b00
        |=> cnt3_q == 16'h0000)
        else $error("third timer did not wrap");

    fifth_wrap_a: assert property (ovf5 && !rl5 && w5 == 3'b000
        |=> cnt5_q == 24'h000000)
        else $error("fifth timer did not wrap");

    fifth_select_a: assert property (run5 && ctl5_q[6] && !slow_oscillator_32k
        && w5 == 3'b000 |=> $stable(cnt5_q))
        else $error("fifth timer stepped without selected tick");

    fast_select_a: assert property (run5 && !ctl5_q[6] && !fast_internal_oscillator
        && w5 == 3'b000 |=> $stable(cnt5_q))
        else $error("fifth timer stepped without fast tick");

    reload_write_a: assert property (w3[0] && rl3 |=> rld3_q[7:0] == $past(wb))
        else $error("reload byte not written");

    free_write_a: assert property (w4[1] && !rl4 |=> cnt4_q[15:8] == $past(wb))
        else $error("live count byte not written");

    fifth_write_a: assert property (w5[2] && !rl5 |=> cnt5_q[23:16] == $past(wb))
        else $error("fifth count byte not written");

    fifth_irq_a: assert property (fifth_irq == (ctl5_q[7] && ctl5_q[0]))
        else $error("fifth irq mismatch");

    third_irq_a: assert property (third_irq == (ctl34_q[3] && ctl34_q[0]))
        else $error("third irq mismatch");

    fourth_irq_a: assert property (fourth_irq == (ctl34_q[7] && ctl34_q[4]))
        else $error("fourth irq mismatch");

    unused_bits_a: assert property (ctl5_q[2:1] == 2'b00)
        else $error("fifth unused bits set");

    third_ovf_c: cover property (ovf3 && rl3);
    fifth_ovf_c: cover property (ovf5 && ctl5_q[6]);
    clear_race_c: cover property (ovf4 && w_c34);
    fourth_reload_c: cover property (ovf4 && rl4);
    fifth_reload_c: cover property (ovf5 && rl5);

endmodule : sys_timers

// file: logic/sys_timers_pkg.sv
// Package: register map, field positions and reset values of the system timers
package sys_timers_pkg;

    // ----------------------------------------------------------------
    // Register indices (printed offsets; byte address is four times these)
    // ----------------------------------------------------------------
    localparam logic [15:0] timer_four_count_low_idx = 16'h00ac;
    localparam logic [15:0] timer_four_count_high_idx = 16'h00ad;
    localparam logic [15:0] timer_three_count_low_idx = 16'h00ae;
    localparam logic [15:0] timer_three_count_high_idx = 16'h00af;
    localparam logic [15:0] timers_three_four_control_idx = 16'h00cf;
    localparam logic [15:0] timer_five_control_idx = 16'ha068;
    localparam logic [15:0] timer_five_count_low_idx = 16'ha069;
    localparam logic [15:0] timer_five_count_mid_idx = 16'ha06a;
    localparam logic [15:0] timer_five_count_top_idx = 16'ha06b;

    // ----------------------------------------------------------------
    // Shared control register fields
    // ----------------------------------------------------------------
    localparam int fourth_overflow_flag_bit = 7;
    localparam int fourth_reload_select_bit = 6;
    localparam int fourth_run_bit = 5;
    localparam int fourth_irq_enable_bit = 4;
    localparam int third_overflow_flag_bit = 3;
    localparam int third_reload_select_bit = 2;
    localparam int third_run_bit = 1;
    localparam int third_irq_enable_bit = 0;

    // ----------------------------------------------------------------
    // Fifth timer control fields
    // ----------------------------------------------------------------
    localparam int fifth_overflow_flag_bit = 7;
    localparam int fifth_clock_select_hi_bit = 6;
    localparam int fifth_reload_select_bit = 4;
    localparam int fifth_run_bit = 3;
    localparam int fifth_irq_enable_bit = 0;
    localparam logic [7:0] fifth_control_write_mask = 8'hf9;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] control_reset = 8'h00;
    localparam logic [15:0] count16_reset = 16'h0000;
    localparam logic [23:0] count24_reset = 24'h000000;

endpackage : sys_timers_pkg

// file: testbench/sys_timers_tb.sv
// Testbench: APB-driven self-checking scenarios for the system timers
module sys_timers_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic fast_internal_oscillator;
    logic slow_oscillator_32k;
    logic third_irq;
    logic fourth_irq;
    logic fifth_irq;
    int miscompares = 0;
    int check_count = 0;

    sys_timers i_sys_timers (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fast_internal_oscillator(fast_internal_oscillator),
        .slow_oscillator_32k(slow_oscillator_32k),
        .third_irq(third_irq), .fourth_irq(fourth_irq), .fifth_irq(fifth_irq)
    );

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask : check_word

    task automatic check_bit(input logic got, input logic exp, input string m);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %b expected %b", $time, m, got, exp);
        end
    endtask : check_bit

    // Request held from setup until pready is seen high; data taken at that edge only
    task automatic apb_xfer(input logic [15:0] idx, input logic wr, input logic [7:0] wd,
                            output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {14'h0000, idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for a slave that never answers
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb_xfer

    task automatic wr(input logic [15:0] idx, input logic [7:0] wd);
        logic [31:0] d;
        logic e;
        apb_xfer(idx, 1'b1, wd, d, e);
    endtask : wr

    task automatic expect_reg(input logic [15:0] idx, input logic [7:0] exp);
        logic [31:0] d;
        logic e;
        apb_xfer(idx, 1'b0, 8'h00, d, e);
        check_word(d, {24'h000000, exp}, "register read");
        check_bit(e, 1'b0, "error response");
    endtask : expect_reg

    // Ticks last one pclk cycle; a gap keeps each one a single step
    task automatic tick(input logic slow, input int n);
        repeat (n) begin
            @(posedge pclk);
            fast_internal_oscillator <= ~slow;
            slow_oscillator_32k <= slow;
            @(posedge pclk);
            fast_internal_oscillator <= 1'b0;
            slow_oscillator_32k <= 1'b0;
        end
    endtask : tick

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_reset_and_map();
        logic [31:0] d;
        logic e;
        expect_reg(sys_timers_pkg::timer_four_count_low_idx, 8'h00);
        expect_reg(sys_timers_pkg::timer_four_count_high_idx, 8'h00);
        expect_reg(sys_timers_pkg::timer_three_count_low_idx, 8'h00);
        expect_reg(sys_timers_pkg::timer_three_count_high_idx, 8'h00);
        expect_reg(sys_timers_pkg::timers_three_four_control_idx, 8'h00);
        expect_reg(sys_timers_pkg::timer_five_control_idx, 8'h00);
        expect_reg(sys_timers_pkg::timer_five_count_low_idx, 8'h00);
        expect_reg(sys_timers_pkg::timer_five_count_mid_idx, 8'h00);
        expect_reg(sys_timers_pkg::timer_five_count_top_idx, 8'h00);
        apb_xfer(16'h0001, 1'b0, 8'h00, d, e);
        check_bit(e, 1'b1, "unmapped error");
        check_word(d, 32'h00000000, "unmapped data");
        $display("test reset and map done");
    endtask : test_reset_and_map

    task automatic test_fourth_reload();
        wr(sys_timers_pkg::timer_four_count_high_idx, 8'hff);
        wr(sys_timers_pkg::timer_four_count_low_idx, 8'hf0);
        wr(sys_timers_pkg::timers_three_four_control_idx, 8'h40);
        wr(sys_timers_pkg::timer_four_count_high_idx, 8'h12);
        wr(sys_timers_pkg::timer_four_count_low_idx, 8'h34);
        repeat (10) @(posedge pclk);
        expect_reg(sys_timers_pkg::timer_four_count_low_idx, 8'hf0);
        expect_reg(sys_timers_pkg::timer_four_count_high_idx, 8'hff);
        wr(sys_timers_pkg::timers_three_four_control_idx, 8'h70);
        repeat (30) @(posedge pclk);
        expect_reg(sys_timers_pkg::timer_four_count_high_idx, 8'h12);
        expect_reg(sys_timers_pkg::timers_three_four_control_idx, 8'hf0);
        check_bit(fourth_irq, 1'b1, "fourth irq");
        wr(sys_timers_pkg::timers_three_four_control_idx, 8'he0);
        // The write lands at the edge the task returns on; look one edge later
        @(posedge pclk);
        check_bit(fourth_irq, 1'b0, "fourth irq masked");
        expect_reg(sys_timers_pkg::timers_three_four_control_idx, 8'he0);
        wr(sys_timers_pkg::timers_three_four_control_idx, 8'h40);
        expect_reg(sys_timers_pkg::timers_three_four_control_idx, 8'h40);
        $display("test fourth reload done");
    endtask : test_fourth_reload

    task automatic test_third_free_run();
        wr(sys_timers_pkg::timer_three_count_high_idx, 8'hff);
        wr(sys_timers_pkg::timer_three_count_low_idx, 8'hf0);
        wr(sys_timers_pkg::timers_three_four_control_idx, 8'h03);
        repeat (30) @(posedge pclk);
        expect_reg(sys_timers_pkg::timer_three_count_high_idx, 8'h00);
        expect_reg(sys_timers_pkg::timers_three_four_control_idx, 8'h0b);
        check_bit(third_irq, 1'b1, "third irq");
        wr(sys_timers_pkg::timers_three_four_control_idx, 8'h00);
        @(posedge pclk);
        check_bit(third_irq, 1'b0, "third irq cleared");
        wr(sys_timers_pkg::timer_three_count_low_idx, 8'h55);
        wr(sys_timers_pkg::timers_three_four_control_idx, 8'h04);
        wr(sys_timers_pkg::timer_three_count_low_idx, 8'h99);
        repeat (10) @(posedge pclk);
        expect_reg(sys_timers_pkg::timer_three_count_high_idx, 8'h00);
        expect_reg(sys_timers_pkg::timer_three_count_low_idx, 8'h55);
        expect_reg(sys_timers_pkg::timers_three_four_control_idx, 8'h04);
        $display("test third free run done");
    endtask : test_third_free_run

    task automatic test_fifth_sources();
        logic [7:0] sel;
        for (int s = 0; s < 4; s++) begin
            sel = 8'(s << 5);
            wr(sys_timers_pkg::timer_five_control_idx, 8'h00);
            wr(sys_timers_pkg::timer_five_count_top_idx, 8'hff);
            wr(sys_timers_pkg::timer_five_count_mid_idx, 8'hff);
            wr(sys_timers_pkg::timer_five_count_low_idx, 8'hf0);
            wr(sys_timers_pkg::timer_five_control_idx, sel | 8'h0f);
            tick(s < 2, 20);
            expect_reg(sys_timers_pkg::timer_five_count_low_idx, 8'hf0);
            tick(s >= 2, 20);
            expect_reg(sys_timers_pkg::timer_five_count_top_idx, 8'h00);
            expect_reg(sys_timers_pkg::timer_five_count_mid_idx, 8'h00);
            expect_reg(sys_timers_pkg::timer_five_count_low_idx, 8'h04);
            expect_reg(sys_timers_pkg::timer_five_control_idx, sel | 8'h89);
            check_bit(fifth_irq, 1'b1, "fifth irq");
        end
        wr(sys_timers_pkg::timer_five_control_idx, 8'h10);
        @(posedge pclk);
        check_bit(fifth_irq, 1'b0, "fifth irq cleared");
        wr(sys_timers_pkg::timer_five_count_top_idx, 8'h12);
        wr(sys_timers_pkg::timer_five_count_mid_idx, 8'h34);
        wr(sys_timers_pkg::timer_five_count_low_idx, 8'h56);
        expect_reg(sys_timers_pkg::timer_five_count_low_idx, 8'h04);
        wr(sys_timers_pkg::timer_five_control_idx, 8'h00);
        wr(sys_timers_pkg::timer_five_count_top_idx, 8'hff);
        wr(sys_timers_pkg::timer_five_count_mid_idx, 8'hff);
        wr(sys_timers_pkg::timer_five_count_low_idx, 8'hff);
        wr(sys_timers_pkg::timer_five_control_idx, 8'h18);
        tick(1'b0, 3);
        expect_reg(sys_timers_pkg::timer_five_count_top_idx, 8'h12);
        expect_reg(sys_timers_pkg::timer_five_count_mid_idx, 8'h34);
        expect_reg(sys_timers_pkg::timer_five_count_low_idx, 8'h58);
        expect_reg(sys_timers_pkg::timer_five_control_idx, 8'h98);
        check_bit(fifth_irq, 1'b0, "fifth irq disabled");
        $display("test fifth sources done");
    endtask : test_fifth_sources

    // ----------------------------------------------------------------
    // Run control
    // ----------------------------------------------------------------
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up

    // Whole run is under a thousand cycles; this limit only catches a hang
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        wrap_up();
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h00000000;
        pwdata = 32'h00000000;
        fast_internal_oscillator = 1'b0;
        slow_oscillator_32k = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        test_reset_and_map();
        test_fourth_reload();
        test_third_free_run();
        test_fifth_sources();
        wrap_up();
    end
endmodule : sys_timers_tb
